// ===== pzs_defines.vh
// constants for the pipelined zero-turnaround static memory port
// assumes inclusion by bare name from the design file; definitions only
//
// Notes on behaviour
// - address is captured only on a load edge while enabled and selected.
// - load low while selected takes new address and control values.
// - load low while deselected ends any burst in progress.
// - advance steps the burst counter and ignores the address pins.
// - read_write_select on a load picks the access; data moves two cycles later.
// - clock_enable_n high freezes every register as if no edge came.
// - one active-low write enable per 9-bit lane; only enabled lanes change.
// - byte enables are ignored when the access is a read.
// - enabled lanes reach the array two cycles after enables are sampled.
// - load low with any chip select inactive starts a deselect cycle.
// - data bus goes high impedance two cycles after a deselect.
// - the active-high select acts like the active-low ones, polarity aside.
// - everything except output_drive_n is timed from the rising clock.
// - write data in and read data out are registered at the clock.
// - burst_order_sel high gives interleaved order, low gives linear.
// - output_drive_n high floats the data pins at once, clock aside.
// - output drive is sequenced inside, so output_drive_n may stay low.
// - one loaded address yields four addresses in turn from the burst counter, then wraps.
// - deselects and blocked loads still finish transfers already queued.
`ifndef PZS_DEFINES_VH
`define PZS_DEFINES_VH

// ----------------------------------------------------------------
// array shape
// ----------------------------------------------------------------
`define PZS_ADDR_W 17
`define PZS_LANES 4
`define PZS_LANE_W 9
`define PZS_BYTE_W 8

// ----------------------------------------------------------------
// burst counter
// ----------------------------------------------------------------
`define PZS_BURST_W 2
`define PZS_BURST_STEP 2'h1
`define PZS_CNT_RST 2'h0

// ----------------------------------------------------------------
// read tap buffer
// ----------------------------------------------------------------
`define PZS_TAP_DEPTH 4
`define PZS_TAP_PTR_W 2

`endif

// ===== pzs_sram.v
// synchronous pipelined static memory port with burst counter and read tap
// assumes a controller that drives all control pins synchronous to clk and
// a testbench that resolves the data wires from the output enables
`timescale 1ns/100ps
`include "pzs_defines.vh"

// ----------------------------------------------------------------
// small valid/ready buffer
// ----------------------------------------------------------------
module pzs_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = `PZS_TAP_DEPTH,
  parameter PTR_W = `PZS_TAP_PTR_W
) (
  input wire clk,
  input wire reset,
  input wire en,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] store [0:DEPTH-1];
  reg [PTR_W-1:0] wr_ptr_r;
  reg [PTR_W-1:0] rd_ptr_r;
  reg [PTR_W:0] count_r;
  wire push;
  wire pop;
  localparam [PTR_W:0] DEPTH_C = DEPTH;
  localparam [PTR_W-1:0] PTR_ONE = 1;
  localparam [PTR_W:0] CNT_ONE = 1;

  assign in_ready = (count_r != DEPTH_C);
  assign out_valid = (count_r != {(PTR_W+1){1'b0}});
  assign out_data = store[rd_ptr_r];
  assign push = en & in_valid & in_ready;
  assign pop = en & out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      store[wr_ptr_r] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      wr_ptr_r <= {PTR_W{1'b0}};
      rd_ptr_r <= {PTR_W{1'b0}};
      count_r <= {(PTR_W+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + PTR_ONE;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + PTR_ONE;
      end
      if (push & ~pop) begin
        count_r <= count_r + CNT_ONE;
      end else if (pop & ~push) begin
        count_r <= count_r - CNT_ONE;
      end
    end
  end
endmodule

// ----------------------------------------------------------------
// memory port top
// ----------------------------------------------------------------
module pzs_sram #(
  parameter ADDR_W = `PZS_ADDR_W,
  parameter LANES = `PZS_LANES,
  parameter TAP_DEPTH = `PZS_TAP_DEPTH
) (
  input wire clk,
  input wire reset,
  input wire clock_enable_n,
  input wire load_or_advance,
  input wire read_write_select,
  input wire chip_select_a_n,
  input wire chip_select_b_n,
  input wire chip_select_hi,
  input wire [ADDR_W-1:0] addr_in,
  input wire [LANES-1:0] byte_write_n,
  input wire burst_order_sel,
  input wire output_drive_n,
  input wire [LANES*`PZS_BYTE_W-1:0] dq_bus_in,
  output reg [LANES*`PZS_BYTE_W-1:0] dq_bus_out,
  output wire dq_bus_oe,
  input wire [LANES-1:0] dq_parity_bits_in,
  output reg [LANES-1:0] dq_parity_bits_out,
  output wire dq_parity_bits_oe,
  output wire rd_tap_valid,
  input wire rd_tap_ready,
  output wire [LANES*`PZS_LANE_W-1:0] rd_tap_data,
  output wire rd_tap_room
);
  localparam WORD_W = LANES * `PZS_LANE_W;
  localparam DEPTH = 1 << ADDR_W;
  localparam BW = `PZS_BURST_W;

  // ----------------------------------------------------------------
  // array and pin-to-word mapping
  // ----------------------------------------------------------------
  reg [WORD_W-1:0] mem [0:DEPTH-1];
  wire [WORD_W-1:0] wr_word;
  wire [WORD_W-1:0] rd_word;

  // lane i holds its data byte low and its parity bit on top
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : lane_map
      assign wr_word[g*`PZS_LANE_W +: `PZS_LANE_W] =
        {dq_parity_bits_in[g], dq_bus_in[g*`PZS_BYTE_W +: `PZS_BYTE_W]};
    end
  endgenerate

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire active;
  wire selected;
  wire do_load;
  wire do_desel;
  wire do_adv;

  assign active = ~clock_enable_n;
  assign selected = ~chip_select_a_n & ~chip_select_b_n & chip_select_hi;
  assign do_load = ~load_or_advance & selected;
  assign do_desel = ~load_or_advance & ~selected;
  assign do_adv = load_or_advance;

  // ----------------------------------------------------------------
  // burst counter
  // ----------------------------------------------------------------
  reg burst_on_r;
  reg burst_wr_r;
  reg [ADDR_W-1:0] base_addr_r;
  reg [BW-1:0] burst_cnt_r;
  wire [BW-1:0] cnt_nxt;
  wire [BW-1:0] low_nxt;
  wire [ADDR_W-1:0] adv_addr;

  assign cnt_nxt = burst_cnt_r + `PZS_BURST_STEP;
  // linear wraps inside the aligned group of four, interleaved flips bits
  assign low_nxt = burst_order_sel ?
    (base_addr_r[BW-1:0] ^ cnt_nxt) :
    (base_addr_r[BW-1:0] + cnt_nxt);
  assign adv_addr = {base_addr_r[ADDR_W-1:BW], low_nxt};

  // ----------------------------------------------------------------
  // pipeline: stage 1 after the command edge, stage 2 one edge later
  // ----------------------------------------------------------------
  reg s1_vld_r;
  reg s1_wr_r;
  reg [ADDR_W-1:0] s1_addr_r;
  reg [LANES-1:0] s1_be_n_r;
  reg s2_vld_r;
  reg s2_wr_r;
  reg [ADDR_W-1:0] s2_addr_r;
  reg [LANES-1:0] s2_be_n_r;
  reg drive_r;

  always @(posedge clk) begin
    if (reset) begin
      burst_on_r <= 1'b0;
      burst_wr_r <= 1'b0;
      base_addr_r <= {ADDR_W{1'b0}};
      burst_cnt_r <= `PZS_CNT_RST;
      s1_vld_r <= 1'b0;
      s1_wr_r <= 1'b0;
      s1_addr_r <= {ADDR_W{1'b0}};
      s1_be_n_r <= {LANES{1'b1}};
      s2_vld_r <= 1'b0;
      s2_wr_r <= 1'b0;
      s2_addr_r <= {ADDR_W{1'b0}};
      s2_be_n_r <= {LANES{1'b1}};
    end else if (active) begin
      // stage 2 always moves on, so queued work finishes
      s2_vld_r <= s1_vld_r;
      s2_wr_r <= s1_wr_r;
      s2_addr_r <= s1_addr_r;
      s2_be_n_r <= s1_be_n_r;
      if (do_load) begin
        burst_on_r <= 1'b1;
        burst_wr_r <= ~read_write_select;
        base_addr_r <= addr_in;
        burst_cnt_r <= `PZS_CNT_RST;
        s1_vld_r <= 1'b1;
        s1_wr_r <= ~read_write_select;
        s1_addr_r <= addr_in;
        // a read leaves every lane disabled
        s1_be_n_r <= read_write_select ?
          {LANES{1'b1}} : byte_write_n;
      end else if (do_desel) begin
        burst_on_r <= 1'b0;
        s1_vld_r <= 1'b0;
        s1_be_n_r <= {LANES{1'b1}};
      end else if (do_adv & burst_on_r) begin
        // address pins are not looked at here
        burst_cnt_r <= cnt_nxt;
        s1_vld_r <= 1'b1;
        s1_wr_r <= burst_wr_r;
        s1_addr_r <= adv_addr;
        s1_be_n_r <= burst_wr_r ?
          byte_write_n : {LANES{1'b1}};
      end else begin
        s1_vld_r <= 1'b0;
        s1_be_n_r <= {LANES{1'b1}};
      end
    end
  end

  // ----------------------------------------------------------------
  // data stage: two edges after the command
  // ----------------------------------------------------------------
  wire rd_now;
  wire wr_now;
  integer i;

  assign rd_now = active & s2_vld_r & ~s2_wr_r;
  assign wr_now = active & s2_vld_r & s2_wr_r;
  assign rd_word = mem[s2_addr_r];

  // the array holds no reset: contents survive like the real cells
  always @(posedge clk) begin
    if (wr_now & ~reset) begin
      for (i = 0; i < LANES; i = i + 1) begin
        if (~s2_be_n_r[i]) begin
          mem[s2_addr_r][i*`PZS_LANE_W +: `PZS_LANE_W] <=
            wr_word[i*`PZS_LANE_W +: `PZS_LANE_W];
        end
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      drive_r <= 1'b0;
      dq_bus_out <= {(LANES*`PZS_BYTE_W){1'b0}};
      dq_parity_bits_out <= {LANES{1'b0}};
    end else if (active) begin
      // drive only on read slots; a write or idle slot frees the bus
      drive_r <= rd_now;
      if (rd_now) begin
        for (i = 0; i < LANES; i = i + 1) begin
          dq_bus_out[i*`PZS_BYTE_W +: `PZS_BYTE_W] <=
            rd_word[i*`PZS_LANE_W +: `PZS_BYTE_W];
          dq_parity_bits_out[i] <=
            rd_word[i*`PZS_LANE_W + `PZS_BYTE_W];
        end
      end
    end
  end

  // the one path not timed by the clock: output_drive_n floats at once
  assign dq_bus_oe = drive_r & ~output_drive_n;
  assign dq_parity_bits_oe = drive_r & ~output_drive_n;

  // ----------------------------------------------------------------
  // read tap: copy of each read word that finds room, for a local consumer
  // ----------------------------------------------------------------
  // a full tap drops words rather than stalling the memory timing
  pzs_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(TAP_DEPTH),
    .PTR_W(`PZS_TAP_PTR_W)
  ) u_tap (
    .clk(clk),
    .reset(reset),
    .en(active),
    .in_valid(rd_now),
    .in_ready(rd_tap_room),
    .in_data(rd_word),
    .out_valid(rd_tap_valid),
    .out_ready(rd_tap_ready),
    .out_data(rd_tap_data)
  );
endmodule

// ===== pzs_sram_chk.sv
// checker for the memory port top: slot timing, float and freeze
// assumes bind onto pzs_sram with the defines header on the path
`timescale 1ns/100ps
`include "pzs_defines.vh"
module pzs_sram_chk #(
  parameter LANES = `PZS_LANES
) (
  input wire clk,
  input wire reset,
  input wire clock_enable_n,
  input wire load_or_advance,
  input wire read_write_select,
  input wire chip_select_a_n,
  input wire chip_select_b_n,
  input wire chip_select_hi,
  input wire output_drive_n,
  input wire [LANES*`PZS_BYTE_W-1:0] dq_bus_out,
  input wire dq_bus_oe,
  input wire dq_parity_bits_oe,
  input wire rd_tap_valid,
  input wire rd_tap_room
);
  // ----
  // slot decode
  // ----
  wire act = !clock_enable_n;
  wire sel = !chip_select_a_n && !chip_select_b_n && chip_select_hi;
  wire ld = act && !load_or_advance;
  wire rd = ld && sel && read_write_select;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_OE_ASYNC: assert property (output_drive_n |-> !dq_bus_oe)
    else $error("drive on while output drive off");
  AST_PAR_OE: assert property (dq_parity_bits_oe == dq_bus_oe)
    else $error("parity lanes drive apart from data");
  AST_READ_SLOT: assert property (rd ##1 act ##1 act |=>
    output_drive_n || dq_bus_oe) else $error("read slot not driven");
  AST_BURST_SLOT: assert property (rd ##1 (act && load_or_advance)
    ##1 act ##1 act |=> output_drive_n || dq_bus_oe)
    else $error("burst read slot not driven");
  AST_DESEL_FLOAT: assert property ((ld && !sel) ##1 act ##1 act
    |=> !dq_bus_oe) else $error("bus driven after deselect");
  AST_WRITE_FLOAT: assert property ((ld && sel && !read_write_select)
    ##1 act ##1 act |=> !dq_bus_oe) else $error("bus driven in write slot");
  AST_FREEZE: assert property (clock_enable_n |=> $stable(dq_bus_out) &&
    $stable(rd_tap_valid) && $stable(rd_tap_room))
    else $error("state moved on a suspended edge");
  AST_HOLD_OUT: assert property ((ld && !(sel && read_write_select))
    ##1 act ##1 act |=> $stable(dq_bus_out))
    else $error("read data changed in a non-read slot");
  AST_TAP_PUSH: assert property (rd ##1 act ##1 (act && rd_tap_room)
    |=> rd_tap_valid) else $error("read copy missing from tap");
endmodule
bind pzs_sram pzs_sram_chk #(.LANES(LANES)) u_pzs_sram_chk (
  .clk(clk), .reset(reset), .clock_enable_n(clock_enable_n),
  .load_or_advance(load_or_advance), .read_write_select(read_write_select),
  .chip_select_a_n(chip_select_a_n), .chip_select_b_n(chip_select_b_n),
  .chip_select_hi(chip_select_hi), .output_drive_n(output_drive_n),
  .dq_bus_out(dq_bus_out), .dq_bus_oe(dq_bus_oe),
  .dq_parity_bits_oe(dq_parity_bits_oe), .rd_tap_valid(rd_tap_valid),
  .rd_tap_room(rd_tap_room));

// ===== pzs_ctrl_model.sv
// controller side of the data wires: write words and bus resolution
// assumes drv_en is raised only in the cycle before a write slot
`timescale 1ns/100ps
module pzs_ctrl_model (
  input wire clk,
  input wire dev_oe,
  input wire [31:0] dev_bus,
  input wire [3:0] dev_par,
  input wire drv_en,
  input wire [35:0] drv_word,
  output reg [31:0] wire_bus,
  output reg [3:0] wire_par
);
  reg [35:0] last_r = 36'h0;
  // ----
  // wire resolution
  // ----
  // controller wins at a read-to-write turn; a released bus toggles
  always @* begin
    if (drv_en)
      {wire_par, wire_bus} = drv_word;
    else if (dev_oe)
      {wire_par, wire_bus} = {dev_par, dev_bus};
    else
      {wire_par, wire_bus} = ~last_r;
  end
  always @(posedge clk) begin
    last_r <= {wire_par, wire_bus};
  end
endmodule

// ===== pzs_sram_test.sv
// self-checking bench: random slots with corner sequences
// assumes the controller model resolves the data wires
`timescale 1ns/100ps
module pzs_sram_test;
  reg clk = 0, reset = 1, clock_enable_n = 0, load_or_advance = 0;
  reg read_write_select = 0, chip_select_a_n = 1, chip_select_b_n = 1;
  reg chip_select_hi = 0, burst_order_sel = 0, output_drive_n = 0;
  reg rd_tap_ready = 0, drv_en = 0, open = 0, rw_o = 0;
  reg rd_last = 0, rd_chk = 0;
  reg [3:0] addr_in = 4'h0, byte_write_n = 4'hF, base, na;
  reg [1:0] k;
  reg [9:0] p1, p2;
  reg [35:0] drv_word = 36'h0, exp_rd, mem [0:15];
  logic [35:0] q [$];
  integer seed, miscompares, check_count, i, ph, n, r, dw;
  wire [31:0] dq_bus_in, dq_bus_out;
  wire [3:0] dq_parity_bits_in, dq_parity_bits_out;
  wire [35:0] rd_tap_data;
  wire dq_bus_oe, dq_parity_bits_oe, rd_tap_valid, rd_tap_room;
  always #25 clk = ~clk;
  pzs_sram #(.ADDR_W(4)) u_pzs_sram (
    .clk(clk), .reset(reset), .clock_enable_n(clock_enable_n),
    .load_or_advance(load_or_advance), .read_write_select(read_write_select),
    .chip_select_a_n(chip_select_a_n), .chip_select_b_n(chip_select_b_n),
    .chip_select_hi(chip_select_hi), .addr_in(addr_in),
    .byte_write_n(byte_write_n), .burst_order_sel(burst_order_sel),
    .output_drive_n(output_drive_n), .dq_bus_in(dq_bus_in),
    .dq_bus_out(dq_bus_out), .dq_bus_oe(dq_bus_oe),
    .dq_parity_bits_in(dq_parity_bits_in),
    .dq_parity_bits_out(dq_parity_bits_out),
    .dq_parity_bits_oe(dq_parity_bits_oe), .rd_tap_valid(rd_tap_valid),
    .rd_tap_ready(rd_tap_ready), .rd_tap_data(rd_tap_data),
    .rd_tap_room(rd_tap_room));
  pzs_ctrl_model u_pzs_ctrl_model (.clk(clk), .dev_oe(dq_bus_oe),
    .dev_bus(dq_bus_out), .dev_par(dq_parity_bits_out), .drv_en(drv_en),
    .drv_word(drv_word), .wire_bus(dq_bus_in), .wire_par(dq_parity_bits_in));
  // ----
  // reference and drivers
  // ----
  function [35:0] unl(input [35:0] w);
    integer j;
    for (j = 0; j < 4; j = j + 1) begin
      unl[32+j] = w[9*j+8];
      unl[8*j+:8] = w[9*j+:8];
    end
  endfunction
  task chk(input [35:0] got, input [35:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task step;
    begin
      if (!load_or_advance) begin
        open = !chip_select_a_n && !chip_select_b_n && chip_select_hi;
        base = addr_in;
        rw_o = read_write_select;
        k = 2'h0;
      end else
        k = k + 2'h1;
      na = {base[3:2], burst_order_sel ? base[1:0] ^ k : base[1:0] + k};
      if (p2[9:8] == 2'h2)
        for (i = 0; i < 4; i = i + 1)
          if (!p2[i])
            mem[p2[7:4]][9*i+:9] = {drv_word[32+i], drv_word[8*i+:8]};
      n = q.size();
      if (n != 0 && rd_tap_ready)
        q.pop_front();
      if (p2[9:8] == 2'h1) begin
        exp_rd = mem[p2[7:4]];
        rd_chk = 1;
        if (n < 4)
          q.push_back(exp_rd);
      end
      rd_last = (p2[9:8] == 2'h1);
      p2 = p1;
      p1 = {open ? (rw_o ? 2'h1 : 2'h2) : 2'h0, na, byte_write_n};
    end
  endtask
  task cycle(input c, input l, input w, input [2:0] s, input [3:0] a,
    input [3:0] b);
    begin
      @(posedge clk);
      if (rd_chk)
        chk({dq_parity_bits_out, dq_bus_out}, unl(exp_rd));
      rd_chk = 0;
      chk(dq_bus_oe, rd_last & !output_drive_n);
      chk(dq_parity_bits_oe, rd_last & !output_drive_n);
      chk(rd_tap_valid, q.size() != 0);
      chk(rd_tap_room, q.size() < 4);
      if (q.size() != 0)
        chk(rd_tap_data, q[0]);
      if (!clock_enable_n)
        step;
      dw = $random(seed);
      clock_enable_n <= c;
      load_or_advance <= l;
      read_write_select <= w;
      {chip_select_a_n, chip_select_b_n, chip_select_hi} <= s;
      addr_in <= a;
      byte_write_n <= b;
      drv_en <= (p2[9:8] == 2'h2);
      drv_word <= {dw[7:4], dw};
    end
  endtask
  task do_reset;
    begin
      reset <= 1;
      repeat (8) @(posedge clk);
      reset <= 0;
      open = 0;
      p1 = 10'h0;
      p2 = 10'h0;
      rd_last = 0;
      rd_chk = 0;
      q.delete();
    end
  endtask
  task final_report;
    begin
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    seed = 42743;
    miscompares = 0;
    check_count = 0;
    for (ph = 0; ph < 2; ph = ph + 1) begin
      burst_order_sel <= ph[0];
      do_reset;
      // full burst write, read back at once, then select drop and stall
      cycle(0, 0, 0, 3'h1, 4'h5, 4'h0);
      repeat (3) cycle(0, 1, 0, 3'h1, 4'hF, 4'h0);
      cycle(0, 0, 1, 3'h1, 4'h6, 4'hF);
      cycle(0, 1, 1, 3'h1, 4'h0, 4'h0);
      cycle(0, 0, 1, 3'h0, 4'h7, 4'h0);
      cycle(1, 0, 1, 3'h1, 4'h7, 4'h0);
      repeat (2000) begin
        r = $random(seed);
        cycle(r[2:0] == 0, r[3], r[4], r[7:5] == 0 ? r[10:8] : 3'h1,
          r[14:11], r[18:15]);
        rd_tap_ready <= r[19];
        output_drive_n <= (r[23:20] == 0);
      end
      repeat (4) cycle(0, 0, 0, 3'h6, 4'h0, 4'hF);
      $display("test %0d done", ph);
    end
    final_report;
  end
  initial begin
    repeat (10000) @(posedge clk);
    miscompares = miscompares + 1;
    final_report;
  end
endmodule
